// *** rtl/psd_simd_alu.sv ***
// packed simd alu with lane ops, extract/insert and dot products
//
// What this block does
// - lane add, per-lane wrap, no carry
// - lane subtract, per-lane wrap, no borrow
// - signed average: wrapped sum, arithmetic shift
// - unsigned average: zero-extended immediate, logical shift
// - signed min picks first when strictly less
// - signed max picks first when strictly greater
// - unsigned min/max compare unsigned, zero-extend
// - shift amount uses low 4/3 bits
// - logical shifts zero-fill, arithmetic replicates sign
// - lane or, xor, and
// - absolute value negates negative lanes only
// - signed extract selected lane, sign-extend
// - unsigned extract selected lane, zero-extend
// - insert low lane, keep other bits
// - unsigned dot product of lanes
// - mixed dot: first unsigned, second signed
// - signed dot product of lanes
// - accumulating dot adds old destination
// - scalar form replicates low source lane
// - immediate form extends six bits, replicates
// - lane zero is least significant
// - operations exist only when extension enabled
`timescale 1ns/1ps
`default_nettype none

module psd_simd_alu import psd_pkg::*; #(
  parameter bit custom_ext_enable_param = 1'b1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // request from decode stage
  input wire logic req_valid,
  input wire psd_req_type req_in,
  // answer toward writeback
  output var psd_resp_type resp_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // ops whose immediate is zero-extended; dotu counts as all-unsigned
  function automatic logic imm_is_zext(input psd_op_type op);
    imm_is_zext = op inside {PSD_OP_AVGU, PSD_OP_MINU, PSD_OP_MAXU, PSD_OP_SRL,
      PSD_OP_SRA, PSD_OP_SLL, PSD_OP_DOTU, PSD_OP_SDOTU};
  endfunction : imm_is_zext

  // widen a lane held in 16 bits to its signed 16-bit form
  function automatic logic [15:0] sext_lane(input logic [15:0] x, input logic bm);
    sext_lane = bm ? {{8{x[7]}}, x[7:0]} : x;
  endfunction : sext_lane

  // second operand: vector, scalar replicate or immediate replicate
  function automatic logic [31:0] op2_build(input psd_req_type r);
    logic [15:0] imm_l;
    logic [31:0] v;
    imm_l = imm_is_zext(r.op) ? {10'h000, r.six_bit_immediate}
                              : {{10{r.six_bit_immediate[5]}}, r.six_bit_immediate};
    case (r.form)
      PSD_FORM_SC: v = r.byte_mode ? {4{r.src2[7:0]}} : {2{r.src2[15:0]}};
      PSD_FORM_SCI: v = r.byte_mode ? {4{imm_l[7:0]}} : {2{imm_l}};
      default: v = r.src2;
    endcase
    op2_build = v;
  endfunction : op2_build

  // one lane of the element-wise alu; upper byte ignored in byte mode
  function automatic logic [15:0] lane_fn(input psd_op_type op, input logic [15:0] a,
                                          input logic [15:0] b, input logic bm);
    logic [15:0] mask;
    logic [15:0] sum;
    logic [3:0] amt;
    logic [15:0] r;
    mask = bm ? PSD_MASK_B : PSD_MASK_H;
    sum = (a + b) & mask;
    amt = bm ? {1'b0, b[2:0]} : b[3:0];
    case (op)
      PSD_OP_ADD: r = sum;
      PSD_OP_SUB: r = (a - b) & mask;
      PSD_OP_AVG: r = 16'($signed(sext_lane(sum, bm)) >>> 1) & mask;
      PSD_OP_AVGU: r = sum >> 1;
      PSD_OP_MIN: r = ($signed(sext_lane(a, bm)) < $signed(sext_lane(b, bm))) ? a : b;
      PSD_OP_MAX: r = ($signed(sext_lane(a, bm)) > $signed(sext_lane(b, bm))) ? a : b;
      PSD_OP_MINU: r = ((a & mask) < (b & mask)) ? a : b;
      PSD_OP_MAXU: r = ((a & mask) > (b & mask)) ? a : b;
      PSD_OP_SRL: r = (a & mask) >> amt;
      PSD_OP_SRA: r = 16'($signed(sext_lane(a, bm)) >>> amt) & mask;
      PSD_OP_SLL: r = (a << amt) & mask;
      PSD_OP_OR: r = a | b;
      PSD_OP_XOR: r = a ^ b;
      PSD_OP_AND: r = a & b;
      PSD_OP_ABS: r = (bm ? a[7] : a[15]) ? ((~a + 16'h0001) & mask) : a;
      default: r = 16'h0000;
    endcase
    lane_fn = r & mask;
  endfunction : lane_fn

  // one lane product, each side widened signed or unsigned
  function automatic logic [31:0] dot_lane(input logic [15:0] a, input logic [15:0] b,
                                           input logic bm, input logic sa, input logic sb);
    logic signed [16:0] ea;
    logic signed [16:0] eb;
    logic signed [33:0] p;
    ea = bm ? $signed({{9{sa & a[7]}}, a[7:0]}) : $signed({sa & a[15], a});
    eb = bm ? $signed({{9{sb & b[7]}}, b[7:0]}) : $signed({sb & b[15], b});
    p = ea * eb;
    dot_lane = p[31:0];
  endfunction : dot_lane

  ////////////////////////////////////////////////////////////////////////////
  // datapath

  logic [31:0] op2; // formed second operand
  logic [31:0] simd_res; // element-wise result
  logic [31:0] dot_res; // dot product result
  logic [31:0] bit_res; // extract/insert result
  logic known_op; // decoded a supported operation
  psd_resp_type resp_next; // next answer

  assign op2 = op2_build(req_in);

  // element-wise lanes; index 0 sits in the low bits
  always_comb begin
    logic [15:0] t;
    t = 16'h0000;
    simd_res = 32'h0000_0000;
    if (req_in.byte_mode) begin
      for (int i = 0; i < 4; i++) begin
        t = lane_fn(req_in.op, {8'h00, req_in.src1[i*8+:8]}, {8'h00, op2[i*8+:8]}, 1'b1);
        simd_res[i*8+:8] = t[7:0];
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        t = lane_fn(req_in.op, req_in.src1[i*16+:16], op2[i*16+:16], 1'b0);
        simd_res[i*16+:16] = t;
      end
    end
  end

  // dot products; the sum simply wraps, no flag is kept
  always_comb begin
    logic sa;
    logic sb;
    sa = req_in.op inside {PSD_OP_DOTS, PSD_OP_SDOTS};
    sb = req_in.op inside {PSD_OP_DOTS, PSD_OP_SDOTS, PSD_OP_DOTUS, PSD_OP_SDOTUS};
    dot_res = 32'h0000_0000;
    if (req_in.op inside {PSD_OP_SDOTU, PSD_OP_SDOTUS, PSD_OP_SDOTS}) begin
      dot_res = req_in.dest_old;
    end
    if (req_in.byte_mode) begin
      for (int i = 0; i < 4; i++) begin
        dot_res = dot_res + dot_lane({8'h00, req_in.src1[i*8+:8]}, {8'h00, op2[i*8+:8]}, 1'b1, sa, sb);
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        dot_res = dot_res + dot_lane(req_in.src1[i*16+:16], op2[i*16+:16], 1'b0, sa, sb);
      end
    end
  end

  // extract and insert; insert needs the old destination read port
  always_comb begin
    logic [15:0] hsel;
    logic [7:0] bsel;
    hsel = req_in.six_bit_immediate[0] ? req_in.src1[31:16] : req_in.src1[15:0];
    bsel = req_in.src1[req_in.six_bit_immediate[1:0]*8+:8];
    bit_res = req_in.dest_old;
    case (req_in.op)
      PSD_OP_EXT: bit_res = req_in.byte_mode ? {{24{bsel[7]}}, bsel} : {{16{hsel[15]}}, hsel};
      PSD_OP_EXTU: bit_res = req_in.byte_mode ? {24'h00_0000, bsel} : {16'h0000, hsel};
      PSD_OP_INS: begin
        if (req_in.byte_mode) begin
          bit_res[req_in.six_bit_immediate[1:0]*8+:8] = req_in.src1[7:0];
        end else begin
          bit_res[req_in.six_bit_immediate[0]*16+:16] = req_in.src1[15:0];
        end
      end
      default: bit_res = req_in.dest_old;
    endcase
  end

  // result select; disabled extension answers illegal with zero data
  always_comb begin
    known_op = 1'b1;
    resp_next.valid = req_valid;
    resp_next.illegal = 1'b0;
    case (req_in.op)
      PSD_OP_EXT, PSD_OP_EXTU, PSD_OP_INS: resp_next.data = bit_res;
      PSD_OP_DOTU, PSD_OP_DOTUS, PSD_OP_DOTS,
      PSD_OP_SDOTU, PSD_OP_SDOTUS, PSD_OP_SDOTS: resp_next.data = dot_res;
      PSD_OP_ADD, PSD_OP_SUB, PSD_OP_AVG, PSD_OP_AVGU, PSD_OP_MIN, PSD_OP_MINU,
      PSD_OP_MAX, PSD_OP_MAXU, PSD_OP_SRL, PSD_OP_SRA, PSD_OP_SLL, PSD_OP_OR,
      PSD_OP_XOR, PSD_OP_AND, PSD_OP_ABS: resp_next.data = simd_res;
      default: begin
        known_op = 1'b0;
        resp_next.data = PSD_RESULT_RST;
      end
    endcase
    if (req_valid && (!custom_ext_enable_param || !known_op)) begin
      resp_next.illegal = 1'b1;
      resp_next.data = PSD_RESULT_RST;
    end
    if (!req_valid) begin
      resp_next.data = PSD_RESULT_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer register: one cycle of latency, a pulse per request
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      resp_out <= '0;
    end else begin
      resp_out <= resp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // every check samples on the rising edge and sleeps while reset is low
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  logic go; // request taken this cycle with extension on
  logic [15:0] avg_sum; // wrapped low-lane sum seen by the average check
  assign go = req_valid && custom_ext_enable_param;
  assign avg_sum = req_in.src1[15:0] + req_in.src2[15:0];

  // halfword add: lanes wrap on their own, no carry crosses bit 16
  add_half_a: assert property (
    go && req_in.op == PSD_OP_ADD && !req_in.byte_mode && req_in.form == PSD_FORM_VV
    |=> resp_out.data == {$past(req_in.src1[31:16] + req_in.src2[31:16]),
                          $past(req_in.src1[15:0] + req_in.src2[15:0])})
    else $error("halfword add lanes wrong");
  // byte subtract: lane one borrows nothing from lane zero
  sub_byte_a: assert property (
    go && req_in.op == PSD_OP_SUB && req_in.byte_mode && req_in.form == PSD_FORM_VV
    |=> resp_out.data[15:8] == $past(req_in.src1[15:8] - req_in.src2[15:8]))
    else $error("byte subtract lane one wrong");
  // signed average: whole wrapped lane shifted right, top bit copied
  avg_sign_a: assert property (
    go && req_in.op == PSD_OP_AVG && !req_in.byte_mode && req_in.form == PSD_FORM_VV
    |=> resp_out.data[15:0] == {$past(avg_sum[15]), $past(avg_sum[15:1])})
    else $error("signed average lost sign");
  // unsigned average with immediate: zero-extended, top bit cleared
  avgu_imm_a: assert property (
    go && req_in.op == PSD_OP_AVGU && !req_in.byte_mode && req_in.form == PSD_FORM_SCI
    |=> resp_out.data[15:0] == ($past(req_in.src1[15:0] + {10'h000, req_in.six_bit_immediate}) >> 1))
    else $error("unsigned average with immediate wrong");
  // signed minimum: first source only when strictly less
  min_sign_a: assert property (
    go && req_in.op == PSD_OP_MIN && !req_in.byte_mode && req_in.form == PSD_FORM_VV
    |=> resp_out.data[15:0] == ($past($signed(req_in.src1[15:0]) < $signed(req_in.src2[15:0]))
        ? $past(req_in.src1[15:0]) : $past(req_in.src2[15:0])))
    else $error("signed minimum wrong");
  // signed maximum on the top byte lane, where unsigned order would differ
  max_byte_a: assert property (
    go && req_in.op == PSD_OP_MAX && req_in.byte_mode && req_in.form == PSD_FORM_VV
    |=> resp_out.data[31:24] == ($past($signed(req_in.src1[31:24]) > $signed(req_in.src2[31:24]))
        ? $past(req_in.src1[31:24]) : $past(req_in.src2[31:24])))
    else $error("signed maximum wrong");
  // unsigned maximum on the low byte lane
  maxu_byte_a: assert property (
    go && req_in.op == PSD_OP_MAXU && req_in.byte_mode && req_in.form == PSD_FORM_VV
    |=> resp_out.data[7:0] == ($past(req_in.src1[7:0] > req_in.src2[7:0])
        ? $past(req_in.src1[7:0]) : $past(req_in.src2[7:0])))
    else $error("unsigned maximum wrong");
  // halfword shift takes only the low four amount bits
  shift_amt_a: assert property (
    go && req_in.op == PSD_OP_SRL && !req_in.byte_mode && req_in.form == PSD_FORM_VV
    |=> resp_out.data[15:0] == ($past(req_in.src1[15:0]) >> $past(req_in.src2[3:0])))
    else $error("halfword shift amount wrong");
  // arithmetic byte shift copies the lane's sign into vacated bits
  sra_byte_a: assert property (
    go && req_in.op == PSD_OP_SRA && req_in.byte_mode && req_in.form == PSD_FORM_VV
    |=> resp_out.data[23:16] == $past(8'($signed(req_in.src1[23:16]) >>> req_in.src2[18:16])))
    else $error("arithmetic byte shift wrong");
  // xor is lane-blind, so the whole word is checked at once
  xor_vv_a: assert property (
    go && req_in.op == PSD_OP_XOR && req_in.form == PSD_FORM_VV
    |=> resp_out.data == $past(req_in.src1 ^ req_in.src2))
    else $error("lane xor wrong");
  // absolute value negates the upper halfword only when it is negative
  abs_half_a: assert property (
    go && req_in.op == PSD_OP_ABS && !req_in.byte_mode
    |=> resp_out.data[31:16] == ($past(req_in.src1[31]) ? $past(16'(-req_in.src1[31:16]))
        : $past(req_in.src1[31:16])))
    else $error("absolute value wrong");
  // signed extract of the top byte lane
  ext_byte_a: assert property (
    go && req_in.op == PSD_OP_EXT && req_in.byte_mode && req_in.six_bit_immediate[1:0] == 2'h3
    |=> resp_out.data == {{24{$past(req_in.src1[31])}}, $past(req_in.src1[31:24])})
    else $error("signed byte extract wrong");
  // unsigned extract leaves the upper half of the answer clear
  extu_half_a: assert property (
    go && req_in.op == PSD_OP_EXTU && !req_in.byte_mode && !req_in.six_bit_immediate[0]
    |=> resp_out.data == {16'h0000, $past(req_in.src1[15:0])})
    else $error("unsigned halfword extract wrong");
  // insert into the upper halfword keeps the lower one
  ins_keep_a: assert property (
    go && req_in.op == PSD_OP_INS && !req_in.byte_mode && req_in.six_bit_immediate[0]
    |=> resp_out.data == {$past(req_in.src1[15:0]), $past(req_in.dest_old[15:0])})
    else $error("insert disturbed other bits");
  // mixed dot: first source zero-extended, second operand sign-extended
  dotus_half_a: assert property (
    go && req_in.op == PSD_OP_DOTUS && !req_in.byte_mode && req_in.form == PSD_FORM_VV
    |=> resp_out.data == $past({16'h0000, req_in.src1[15:0]} * {{16{req_in.src2[15]}}, req_in.src2[15:0]}
        + {16'h0000, req_in.src1[31:16]} * {{16{req_in.src2[31]}}, req_in.src2[31:16]}))
    else $error("mixed-sign dot product wrong");
  // accumulating dot from a scalar operand; the sum wraps with no flag
  sdot_acc_a: assert property (
    go && req_in.op == PSD_OP_SDOTU && !req_in.byte_mode && req_in.form == PSD_FORM_SC
    |=> resp_out.data == $past(req_in.dest_old + req_in.src1[31:16] * req_in.src2[15:0]
        + req_in.src1[15:0] * req_in.src2[15:0]))
    else $error("accumulating dot product wrong");
  // scalar byte form adds the low source-two byte to the top byte lane
  sc_byte_a: assert property (
    go && req_in.op == PSD_OP_ADD && req_in.byte_mode && req_in.form == PSD_FORM_SC
    |=> resp_out.data[31:24] == $past(req_in.src1[31:24] + req_in.src2[7:0]))
    else $error("scalar byte replication wrong");
  // immediate form sign-extends its six bits for a signed operation
  imm_sign_a: assert property (
    go && req_in.op == PSD_OP_ADD && !req_in.byte_mode && req_in.form == PSD_FORM_SCI
    |=> resp_out.data[31:16] == $past(req_in.src1[31:16] + {{10{req_in.six_bit_immediate[5]}},
        req_in.six_bit_immediate}))
    else $error("sign-extended immediate wrong");
  // extension left out: every request answered illegal with zero data
  ext_off_a: assert property (
    req_valid && !custom_ext_enable_param
    |=> resp_out.valid && resp_out.illegal && resp_out.data == 32'h0000_0000)
    else $error("disabled extension not refused");

  // main scenarios: byte add, immediate signed dot, back-to-back insert, refusal
  add_byte_c: cover property (go && req_in.op == PSD_OP_ADD && req_in.byte_mode ##1 resp_out.valid);
  dot_sign_c: cover property (go && req_in.op == PSD_OP_DOTS && req_in.form == PSD_FORM_SCI);
  ins_byte_c: cover property (go && req_in.op == PSD_OP_INS && req_in.byte_mode ##1 go);
  refused_c: cover property (req_valid && !custom_ext_enable_param ##1 resp_out.illegal);

endmodule : psd_simd_alu

`default_nettype wire

// *** rtl/psd_pkg.sv ***
// shared types and constants for the packed simd datapath
`default_nettype none
package psd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // lane geometry
  localparam int unsigned PSD_DATA_W = 32;
  localparam int unsigned PSD_HALF_W = 16;
  localparam int unsigned PSD_BYTE_W = 8;
  localparam int unsigned PSD_IMM_W = 6;
  localparam logic [15:0] PSD_MASK_H = 16'hFFFF;
  localparam logic [15:0] PSD_MASK_B = 16'h00FF;
  localparam logic [31:0] PSD_RESULT_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // operation select from decode
  typedef enum logic [4:0] {
    PSD_OP_ADD = 5'h00, PSD_OP_SUB = 5'h01, PSD_OP_AVG = 5'h02, PSD_OP_AVGU = 5'h03,
    PSD_OP_MIN = 5'h04, PSD_OP_MINU = 5'h05, PSD_OP_MAX = 5'h06, PSD_OP_MAXU = 5'h07,
    PSD_OP_SRL = 5'h08, PSD_OP_SRA = 5'h09, PSD_OP_SLL = 5'h0A, PSD_OP_OR = 5'h0B,
    PSD_OP_XOR = 5'h0C, PSD_OP_AND = 5'h0D, PSD_OP_ABS = 5'h0E, PSD_OP_EXT = 5'h0F,
    PSD_OP_EXTU = 5'h10, PSD_OP_INS = 5'h11, PSD_OP_DOTU = 5'h12, PSD_OP_DOTUS = 5'h13,
    PSD_OP_DOTS = 5'h14, PSD_OP_SDOTU = 5'h15, PSD_OP_SDOTUS = 5'h16, PSD_OP_SDOTS = 5'h17
  } psd_op_type;

  // how the second operand is formed
  typedef enum logic [1:0] {
    PSD_FORM_VV = 2'h0,
    PSD_FORM_SC = 2'h1,
    PSD_FORM_SCI = 2'h2
  } psd_form_type;

  ////////////////////////////////////////////////////////////////////////////
  // request and answer carriers
  typedef struct packed {
    psd_op_type op;
    logic byte_mode;
    psd_form_type form;
    logic [31:0] src1;
    logic [31:0] src2;
    logic [31:0] dest_old;
    logic [5:0] six_bit_immediate;
  } psd_req_type;

  typedef struct packed {
    logic valid;
    logic illegal;
    logic [31:0] data;
  } psd_resp_type;

endpackage : psd_pkg

`default_nettype wire

// *** dv/psd_decode_model.sv ***
// decode-stage and writeback partner that feeds the simd datapath
`timescale 1ns/1ps
`default_nettype none
module psd_decode_model import psd_pkg::*; (
  // clock
  input wire logic sys_clk,
  // request toward the datapath
  output var logic req_valid,
  output var psd_req_type req_in,
  // answer from the datapath
  input wire psd_resp_type resp_out
);
  ////////////////////////////////////////////////////////////////////////////
  // quiet request lines from time zero
  initial begin
    req_valid = 1'b0;
    req_in = '0;
  end
  // back-to-back stream; each answer is caught mid-cycle, plus one idle slot
  // idle operands invert every cycle so a stale request never looks live
  task automatic issue(input psd_req_type reqs[$], output psd_resp_type rsps[$]);
    rsps = {};
    for (int k = 0; k <= reqs.size() + 1; k++) begin
      @(posedge sys_clk);
      req_valid <= (k < reqs.size());
      req_in <= (k < reqs.size()) ? reqs[k] : psd_req_type'(~req_in);
      if (k > 0) begin
        @(negedge sys_clk);
        rsps.push_back(resp_out);
      end
    end
  endtask : issue
endmodule : psd_decode_model
`default_nettype wire

// *** dv/psd_simd_alu_tb.sv ***
// self-checking bench for the packed simd datapath
`timescale 1ns/1ps
`default_nettype none
module psd_simd_alu_tb import psd_pkg::*; ;
  ////////////////////////////////////////////////////////////////////////////
  // clock, reset and two request paths (extension on and off)
  logic sys_clk;
  logic reset_n;
  logic req_valid;
  logic req_valid_off;
  psd_req_type req_in;
  psd_req_type req_in_off;
  psd_resp_type resp_out;
  psd_resp_type resp_off;
  int mismatches;
  int n_checks;

  // 40 MHz
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  psd_simd_alu #(.custom_ext_enable_param(1'b1)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .req_valid(req_valid), .req_in(req_in), .resp_out(resp_out));
  // copy built without the extension
  psd_simd_alu #(.custom_ext_enable_param(1'b0)) dut_off (.sys_clk(sys_clk), .reset_n(reset_n),
    .req_valid(req_valid_off), .req_in(req_in_off), .resp_out(resp_off));
  psd_decode_model host (.sys_clk(sys_clk), .req_valid(req_valid), .req_in(req_in), .resp_out(resp_out));
  psd_decode_model host_off (.sys_clk(sys_clk), .req_valid(req_valid_off), .req_in(req_in_off),
    .resp_out(resp_off));

  ////////////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic check(input logic [33:0] seen, input logic [33:0] want, input string what);
    n_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("MISMATCH t=%0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // lane reference in plain integers; signed lanes folded by hand
  function automatic logic [33:0] model(input psd_req_type r);
    int w, m, idx, ua, ub, sa, sb, sh, t, v;
    logic [31:0] res, imm;
    longint acc;
    w = r.byte_mode ? 8 : 16;
    m = (1 << w) - 1;
    res = 32'h0000_0000;
    acc = 0;
    idx = r.byte_mode ? int'(r.six_bit_immediate[1:0]) : int'(r.six_bit_immediate[0]);
    imm = {{26{r.six_bit_immediate[5]}}, r.six_bit_immediate};
    if (r.op inside {PSD_OP_AVGU, PSD_OP_MINU, PSD_OP_MAXU, PSD_OP_SRL, PSD_OP_SRA, PSD_OP_SLL,
        PSD_OP_DOTU, PSD_OP_SDOTU}) begin
      imm[31:6] = '0;
    end
    for (int i = 0; i < 32 / w; i++) begin
      ua = int'((r.src1 >> (i * w)) & m);
      ub = int'(((r.form == PSD_FORM_VV) ? r.src2 >> (i * w) : (r.form == PSD_FORM_SC) ? r.src2 : imm) & m);
      sa = ua - ((ua >> (w - 1)) << w);
      sb = ub - ((ub >> (w - 1)) << w);
      sh = ub & (w - 1);
      t = (ua + ub) & m;
      v = 0;
      case (r.op)
        PSD_OP_ADD: v = ua + ub;
        PSD_OP_SUB: v = ua - ub;
        PSD_OP_AVG: v = (t - ((t >> (w - 1)) << w)) >>> 1;
        PSD_OP_AVGU: v = t >> 1;
        PSD_OP_MIN: v = (sa < sb) ? ua : ub;
        PSD_OP_MINU: v = (ua < ub) ? ua : ub;
        PSD_OP_MAX: v = (sa > sb) ? ua : ub;
        PSD_OP_MAXU: v = (ua > ub) ? ua : ub;
        PSD_OP_SRL: v = ua >> sh;
        PSD_OP_SRA: v = sa >>> sh;
        PSD_OP_SLL: v = ua << sh;
        PSD_OP_OR: v = ua | ub;
        PSD_OP_XOR: v = ua ^ ub;
        PSD_OP_AND: v = ua & ub;
        PSD_OP_ABS: v = (sa < 0) ? -sa : ua;
        PSD_OP_DOTU, PSD_OP_SDOTU: acc += longint'(ua) * ub;
        PSD_OP_DOTUS, PSD_OP_SDOTUS: acc += longint'(ua) * sb;
        PSD_OP_DOTS, PSD_OP_SDOTS: acc += longint'(sa) * sb;
        PSD_OP_EXT, PSD_OP_EXTU, PSD_OP_INS: v = 0;
        default: return 34'h3_0000_0000;
      endcase
      res |= 32'((v & m) << (i * w));
    end
    v = int'((r.src1 >> (idx * w)) & m);
    case (r.op)
      PSD_OP_EXT: res = 32'(v - ((v >> (w - 1)) << w));
      PSD_OP_EXTU: res = 32'(v);
      PSD_OP_INS: res = (r.dest_old & ~32'(m << (idx * w))) | 32'((r.src1 & m) << (idx * w));
      PSD_OP_DOTU, PSD_OP_DOTUS, PSD_OP_DOTS: res = acc[31:0];
      PSD_OP_SDOTU, PSD_OP_SDOTUS, PSD_OP_SDOTS: res = acc[31:0] + r.dest_old;
      default: res = res;
    endcase
    return {2'b10, res};
  endfunction : model

  // stream a burst back to back, then expect one empty slot
  task automatic run(input psd_req_type q[$], input string what);
    psd_resp_type rsps[$];
    host.issue(q, rsps);
    foreach (q[k]) check(rsps[k], model(q[k]), what);
    check(rsps[q.size()], 34'h0, "idle slot");
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  // lane ops in every width and form; carry, sign and unsigned edges
  task automatic t_lane_ops();
    psd_req_type q[$];
    psd_req_type r;
    logic [31:0] a [2] = '{32'h7F80_FF01, 32'hFFFF_0001};
    logic [31:0] b [2] = '{32'h8101_0180, 32'h0001_FFFF};
    for (int op = 0; op < 15; op++) begin
      for (int m = 0; m < 12; m++) begin
        r = '{psd_op_type'(op), m[0], psd_form_type'((m % 6) / 2), a[m / 6], b[m / 6], 32'h0, 6'h2A};
        // shift amounts keep unused high bits clear
        if (op inside {8, 9, 10}) begin
          r.src2 = 32'h0006_0003;
          r.six_bit_immediate = 6'h05;
        end
        q.push_back(r);
      end
    end
    run(q, "lane ops");
  endtask : t_lane_ops

  // every lane index, high immediate bits set to show they are ignored
  task automatic t_extract_insert();
    psd_req_type q[$];
    for (int op = 15; op < 18; op++) begin
      for (int m = 0; m < 8; m++) begin
        q.push_back('{psd_op_type'(op), m[2], PSD_FORM_VV, 32'h8123_F4E6, 32'h0, 32'hA5A5_5A5A, {4'hF, m[1:0]}});
      end
    end
    run(q, "extract insert");
  endtask : t_extract_insert

  // dot products with an accumulator near the top so the sum wraps
  task automatic t_dot();
    psd_req_type q[$];
    for (int op = 18; op < 24; op++) begin
      for (int m = 0; m < 6; m++) begin
        q.push_back('{psd_op_type'(op), m[0], psd_form_type'(m / 2), 32'hFF80_7F01, 32'h80FF_0181,
                      32'hFFFF_FF00, 6'h2A});
      end
    end
    run(q, "dot products");
  endtask : t_dot

  // unknown op mid-burst, then the same burst with the extension absent
  task automatic t_refused();
    psd_req_type q[$];
    psd_req_type r;
    psd_resp_type rsps[$];
    r = '{PSD_OP_ADD, 1'b0, PSD_FORM_VV, 32'h0001_FFFF, 32'h0001_0001, 32'h0, 6'h00};
    q.push_back(r);
    r.op = psd_op_type'(5'h1F);
    q.push_back(r);
    r.op = PSD_OP_SUB;
    q.push_back(r);
    run(q, "unknown op");
    host_off.issue(q, rsps);
    foreach (q[k]) check(rsps[k], 34'h3_0000_0000, "extension absent");
    check(rsps[q.size()], 34'h0, "idle slot absent");
  endtask : t_refused

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    mismatches = 0;
    n_checks = 0;
    reset_n = 1'b0;
    repeat (8) @(posedge sys_clk);
    check(resp_out, 34'h0, "answer in reset");
    reset_n <= 1'b1;
    t_lane_ops();
    t_extract_insert();
    t_dot();
    t_refused();
    close_out();
  end
endmodule : psd_simd_alu_tb
`default_nettype wire
